// >>> src/nfc_frame_codec_fifo.sv
// nfc framing core: tx encoder, rx decoder, shared fifo, target ram, spi port
// assumes control inputs come from logic on clock_i; pins are asynchronous
module nfc_frame_codec_fifo #(
    parameter int FIFO_DEPTH = nfc_pkg::FIFO_DEPTH,
    parameter int PT_BYTES   = nfc_pkg::PT_BYTES,
    parameter int BIT_CYC    = nfc_pkg::BIT_CYC
) (
    input  wire logic              clock_i,
    input  wire logic              rst_b_i,
    input  wire nfc_pkg::nfc_ctrl_t ctrl_i,
    input  wire logic              tx_start_i,
    input  wire logic              irq_clr_i,
    input  wire logic [15:0]       wut_period_i,
    input  wire logic              osc_ok_i,
    input  wire logic              i2c_en_i,
    input  wire logic              bss_b_i,
    input  wire logic              sclk_i,
    input  wire logic              mosi_i,
    input  wire logic              rx_clk_i,
    input  wire logic              rx_data_i,
    input  wire logic              rx_frame_i,
    input  wire logic              pt_we_i,
    input  wire logic [5:0]        pt_addr_i,
    input  wire logic [7:0]        pt_wdata_i,
    output logic                   miso_o,
    output logic                   miso_oe_b_o,
    output logic                   tx_mod_o,
    output logic                   irq_o,
    output logic                   mcu_clk_o,
    output logic                   meas_trig_o,
    output logic                   tx_busy_o,
    output logic [7:0]             pt_rdata_o
);
    localparam int AW = $clog2(FIFO_DEPTH);

    function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++)
        begin
            if (r[0] ^ d[i])
                r = (r >> 1) ^ nfc_pkg::CRC_POLY;
            else
                r = r >> 1;
        end
        return r;
    endfunction

    nfc_pkg::nfc_pins_t s1, s2, s3;
    always_ff @(posedge clock_i)
    begin
        s1 <= {osc_ok_i, i2c_en_i, bss_b_i, sclk_i, mosi_i, rx_clk_i, rx_data_i, rx_frame_i};
        s2 <= s1;
        s3 <= s2;
    end

    logic ready, normal, transp;
    assign ready  = ctrl_i.enable;
    assign normal = ctrl_i.mode == nfc_pkg::NFC_NORMAL;
    assign transp = ctrl_i.mode == nfc_pkg::NFC_TRANSPARENT;

    // shared fifo; direction follows whoever is filling it
    logic [7:0]  mem [FIFO_DEPTH];
    logic [AW:0] wptr, rptr, count;
    logic        empty, full, push, pop, host_push, host_pop, rx_push, tx_pop;
    logic [7:0]  push_data, fifo_q, spi_byte, rx_byte;
    assign count     = wptr - rptr;
    assign empty     = wptr == rptr;
    assign full      = count == (AW+1)'(FIFO_DEPTH);
    assign push      = (host_push | rx_push) & ~full & ready;
    assign pop       = (host_pop | tx_pop) & ~empty & ready;
    assign push_data = host_push ? spi_byte : rx_byte;
    assign fifo_q    = empty ? 8'h00 : mem[rptr[AW-1:0]];
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            wptr <= '0;
            rptr <= '0;
        end
        else
        begin
            if (push)
            begin
                mem[wptr[AW-1:0]] <= push_data;
                wptr <= wptr + 1'b1;
            end
            if (pop)
                rptr <= rptr + 1'b1;
        end
    end

    // spi slave, mode 0, msb first; i2c engine lives outside this core
    logic       spi_on, sclk_rise, sclk_fall, first;
    logic [2:0] bitc;
    logic [7:0] ish, osr, cmd;
    assign spi_on    = ~s2.i2c_en & ~s2.bss_b;
    assign sclk_rise = spi_on & s2.sclk & ~s3.sclk;
    assign sclk_fall = spi_on & ~s2.sclk & s3.sclk;
    assign spi_byte  = {ish[6:0], s2.mosi};
    assign host_push = sclk_rise & (bitc == 3'd7) & ~first & (cmd == nfc_pkg::CMD_FIFO_LOAD);
    assign host_pop  = sclk_rise & (bitc == 3'd7)
                     & ((first ? spi_byte : cmd) == nfc_pkg::CMD_FIFO_READ);
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i || !spi_on)
        begin
            bitc  <= '0;
            first <= 1'b1;
            ish   <= '0;
            osr   <= '0;
            cmd   <= '0;
        end
        else if (sclk_rise)
        begin
            ish  <= spi_byte;
            bitc <= bitc + 3'd1;
            if (bitc == 3'd7 && first)
            begin
                cmd   <= spi_byte;
                first <= 1'b0;
            end
            if (host_pop)
                osr <= fifo_q;
        end
        else if (sclk_fall)
            osr <= {osr[6:0], 1'b0};
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            miso_o      <= 1'b0;
            miso_oe_b_o <= 1'b1;
        end
        else
        begin
            miso_oe_b_o <= ~((transp & ready) | spi_on);
            if (transp)
                miso_o <= s2.rx_data;
            else if (sclk_fall)
                miso_o <= osr[7];
        end
    end

    // transmit encoder
    nfc_pkg::nfc_tx_state_t tx_state;
    logic [7:0]  tcnt;
    logic [8:0]  tsh;
    logic [3:0]  tnb;
    logic [nfc_pkg::TX_LEN_W-1:0] left;
    logic [15:0] tcrc;
    logic [1:0]  cph;
    logic        tick;
    assign tick   = tcnt == 8'(BIT_CYC - 1);
    assign tx_pop = tx_state == nfc_pkg::TX_LOAD && left != '0 && !empty && ready;
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            tx_state <= nfc_pkg::TX_IDLE;
            tcnt     <= '0;
            tsh      <= '0;
            tnb      <= '0;
            left     <= '0;
            tcrc     <= nfc_pkg::CRC_INIT;
            cph      <= '0;
            tx_mod_o <= 1'b0;
        end
        else
        begin
            tcnt <= (tick || tx_state inside {nfc_pkg::TX_IDLE, nfc_pkg::TX_LOAD})
                    ? 8'h00 : tcnt + 8'h01;
            unique case (tx_state)
                nfc_pkg::TX_IDLE:
                begin
                    tx_mod_o <= transp ? s2.mosi : 1'b0;
                    if (tx_start_i && ready && !transp)
                    begin
                        left     <= ctrl_i.tx_len;
                        tcrc     <= nfc_pkg::CRC_INIT;
                        cph      <= '0;
                        tx_state <= normal ? nfc_pkg::TX_SOF : nfc_pkg::TX_LOAD;
                    end
                end
                nfc_pkg::TX_SOF:
                begin
                    tx_mod_o <= nfc_pkg::SOF_LVL;
                    if (tick)
                        tx_state <= nfc_pkg::TX_LOAD;
                end
                nfc_pkg::TX_LOAD:
                begin
                    tx_mod_o <= 1'b0;
                    if (tx_pop)
                    begin
                        tsh      <= {~^fifo_q, fifo_q};
                        tnb      <= normal ? 4'(nfc_pkg::TX_BITS_PAR) : 4'(nfc_pkg::TX_BITS_RAW);
                        left     <= left - 1'b1;
                        tcrc     <= crc_upd(tcrc, fifo_q);
                        tx_state <= nfc_pkg::TX_BITS;
                    end
                    else if (left == '0 && normal && cph != 2'd2)
                    begin
                        tsh      <= cph == 2'd0 ? {~^tcrc[7:0], tcrc[7:0]}
                                                : {~^tcrc[15:8], tcrc[15:8]};
                        tnb      <= 4'(nfc_pkg::TX_BITS_PAR);
                        cph      <= cph + 2'd1;
                        tx_state <= nfc_pkg::TX_BITS;
                    end
                    else if (left == '0)
                        tx_state <= normal ? nfc_pkg::TX_EOF : nfc_pkg::TX_IDLE;
                end
                nfc_pkg::TX_BITS:
                begin
                    tx_mod_o <= tsh[0];
                    if (tick)
                    begin
                        tsh <= tsh >> 1;
                        tnb <= tnb - 4'd1;
                        if (tnb == 4'd1)
                            tx_state <= nfc_pkg::TX_LOAD;
                    end
                end
                nfc_pkg::TX_EOF:
                begin
                    tx_mod_o <= nfc_pkg::EOF_LVL;
                    if (tick)
                        tx_state <= nfc_pkg::TX_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            tx_busy_o <= 1'b0;
        else
            tx_busy_o <= tx_state != nfc_pkg::TX_IDLE;
    end

    // receive decoder; link clock is sampled, never used as a clock
    logic        rx_on, rx_smp, rx_end, rx_done, par_err, crc_err, ovf;
    logic [8:0]  rsh, nsh;
    logic [3:0]  rcnt;
    logic [15:0] rcrc;
    assign rx_on   = ready & ~transp & (tx_state == nfc_pkg::TX_IDLE);
    assign rx_smp  = rx_on & s2.rx_clk & ~s3.rx_clk & s2.rx_frame;
    assign rx_end  = rx_on & ~s2.rx_frame & s3.rx_frame;
    assign nsh     = {s2.rx_data, rsh[8:1]};
    assign rx_done = rx_smp & (rcnt == (normal ? 4'(nfc_pkg::TX_BITS_PAR - 1)
                                                : 4'(nfc_pkg::TX_BITS_RAW - 1)));
    assign rx_byte = normal ? nsh[7:0] : nsh[8:1];
    assign rx_push = rx_done;
    assign par_err = rx_done & normal & ~(^nsh);
    assign crc_err = rx_end & normal & (rcrc != nfc_pkg::CRC_RESIDUE || rcnt != 4'd0);
    assign ovf     = rx_push & full;
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i || rx_end)
        begin
            rsh  <= '0;
            rcnt <= '0;
            rcrc <= nfc_pkg::CRC_INIT;
        end
        else if (rx_smp)
        begin
            rsh  <= nsh;
            rcnt <= rx_done ? 4'd0 : rcnt + 4'd1;
            if (rx_done && normal)
                rcrc <= crc_upd(rcrc, rx_byte);
        end
    end

    // oscillator watch and interrupt
    logic [7:0] osc_cnt;
    logic       osc_stable, osc_hit;
    assign osc_hit = ready & ~osc_stable & s2.osc_ok
                   & (osc_cnt == 8'(nfc_pkg::OSC_STABLE_CYC - 1));
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i || !ready)
        begin
            osc_cnt    <= '0;
            osc_stable <= 1'b0;
        end
        else if (!osc_stable)
        begin
            osc_cnt    <= s2.osc_ok ? osc_cnt + 8'h01 : 8'h00;
            osc_stable <= osc_hit;
        end
    end

    // set beats clear so an event in the clearing cycle survives
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            irq_o <= 1'b0;
        else if (osc_hit || par_err || crc_err || ovf)
            irq_o <= 1'b1;
        else if (irq_clr_i)
            irq_o <= 1'b0;
    end

    // host clock: off until the oscillator settles, then /2, /4 or /8
    logic [2:0] div;
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
        begin
            div       <= '0;
            mcu_clk_o <= 1'b0;
        end
        else
        begin
            div       <= div + 3'd1;
            mcu_clk_o <= (ctrl_i.clk_cfg != 2'd0 && osc_stable)
                         ? div[ctrl_i.clk_cfg - 2'd1] : 1'b0;
        end
    end

    // wake-up timer, only in the low-power state
    logic [15:0] wcnt;
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i || !ctrl_i.wake || ready)
        begin
            wcnt        <= '0;
            meas_trig_o <= 1'b0;
        end
        else
        begin
            meas_trig_o <= wcnt >= wut_period_i;
            wcnt        <= (wcnt >= wut_period_i) ? 16'h0000 : wcnt + 16'h0001;
        end
    end

    // passive target ram, reachable only when enabled
    logic [7:0] pt_mem [PT_BYTES];
    logic       pt_ok;
    assign pt_ok = ready & (pt_addr_i < 6'(PT_BYTES));
    always_ff @(posedge clock_i)
    begin
        if (pt_ok && pt_we_i)
            pt_mem[pt_addr_i] <= pt_wdata_i;
    end
    always_ff @(posedge clock_i)
    begin
        if (!rst_b_i)
            pt_rdata_o <= '0;
        else
            pt_rdata_o <= pt_ok ? pt_mem[pt_addr_i] : 8'h00;
    end

    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    sequence sof_start_s;
        tx_state == nfc_pkg::TX_IDLE ##1 tx_state == nfc_pkg::TX_SOF;
    endsequence
    sequence transp_hold_s;
        transp [*2];
    endsequence

    osc_irq_a: assert property ($rose(osc_stable) |-> irq_o)
        else $error("oscillator stable without interrupt");
    clk_off_a: assert property ((ctrl_i.clk_cfg == 2'd0) [*2] |-> !mcu_clk_o)
        else $error("host clock runs while switched off");
    tx_sof_a: assert property (sof_start_s |=> tx_mod_o == nfc_pkg::SOF_LVL)
        else $error("sof level missing");
    tx_fetch_a: assert property (tx_pop |=> tx_state == nfc_pkg::TX_BITS
        && rptr == $past(rptr) + 1'b1)
        else $error("tx fetch did not consume a fifo byte");
    transp_tx_a: assert property (transp_hold_s |-> tx_mod_o == $past(s2.mosi))
        else $error("modulation does not follow mosi");
    transp_rx_a: assert property (transp_hold_s |-> miso_o == $past(s2.rx_data))
        else $error("miso does not follow subcarrier");
    fifo_bound_a: assert property (count <= (AW+1)'(FIFO_DEPTH))
        else $error("fifo count beyond depth");
    rx_irq_a: assert property (par_err or crc_err |=> irq_o)
        else $error("receive error without interrupt");
    pwr_down_a: assert property (!ready |=> $stable(wptr) && $stable(rptr))
        else $error("fifo moved in power-down");
    wake_trig_a: assert property (meas_trig_o && wut_period_i != 16'h0000
        |-> $past(!ready && ctrl_i.wake) ##1 !meas_trig_o)
        else $error("wake trigger out of low power");
endmodule

// >>> shared/nfc_pkg.sv
// constants, carriers and enumerations for the nfc frame codec core
// assumes one 50 MHz core clock; every pin is synchronised inside the core
package nfc_pkg;
    localparam int FIFO_DEPTH     = 512;
    localparam int PT_BYTES       = 48;
    localparam int TX_LEN_W       = 13;
    localparam int BIT_CYC        = 8;
    localparam int OSC_STABLE_CYC = 16;
    localparam int TX_BITS_PAR    = 9;
    localparam int TX_BITS_RAW    = 8;
    localparam logic [7:0]  CMD_FIFO_LOAD = 8'h80;
    localparam logic [7:0]  CMD_FIFO_READ = 8'hbf;
    localparam logic [15:0] CRC_INIT      = 16'hffff;
    localparam logic [15:0] CRC_POLY      = 16'h8408;
    localparam logic [15:0] CRC_RESIDUE   = 16'h0000;
    localparam logic        SOF_LVL       = 1'b1;
    localparam logic        EOF_LVL       = 1'b0;

    typedef enum logic [1:0] {
        NFC_NORMAL,
        NFC_STREAM,
        NFC_TRANSPARENT
    } nfc_mode_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_SOF,
        TX_LOAD,
        TX_BITS,
        TX_EOF
    } nfc_tx_state_t;

    typedef struct packed {
        logic                enable;
        logic                wake;
        nfc_mode_t           mode;
        logic [1:0]          clk_cfg;
        logic [TX_LEN_W-1:0] tx_len;
    } nfc_ctrl_t;

    typedef struct packed {
        logic osc_ok;
        logic i2c_en;
        logic bss_b;
        logic sclk;
        logic mosi;
        logic rx_clk;
        logic rx_data;
        logic rx_frame;
    } nfc_pins_t;
endpackage

// >>> tb/nfc_host_model.sv
// host side model: spi master, mode 0, msb first, bss held low per frame
// assumes clock_i is the core clock; sclk half period is 4 core cycles
module nfc_host_model (
    input  wire logic clock_i,
    output logic      bss_b_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // arbitrary code for the regulator adjustment command; the core ignores it
    localparam logic [7:0] ADJ_REG_CMD = 8'hc5;

    initial
    begin
        bss_b_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask

    task automatic put_byte(input logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            mosi_o = b[i];
            tick(4);
            sclk_o = 1'b1;
            tick(4);
            sclk_o = 1'b0;
        end
    endtask

    // sclk stands low between frames; released mosi shows the inverse level
    task automatic frame(input logic [7:0] cmd, input logic [7:0] d[$]);
        tick(1);
        bss_b_o = 1'b0;
        tick(4);
        put_byte(cmd);
        foreach (d[i]) put_byte(d[i]);
        tick(4);
        bss_b_o = 1'b1;
        mosi_o = ~mosi_o;
        tick(4);
    endtask

    // single-byte direct command frame, no payload
    task automatic direct(input logic [7:0] cmd);
        tick(1);
        bss_b_o = 1'b0;
        tick(4);
        put_byte(cmd);
        tick(4);
        bss_b_o = 1'b1;
        tick(4);
    endtask

    // power-on access frame; the core has no such register, so it is ignored
    task automatic init();
        frame(8'hfc, '{8'h04, 8'h10});
        direct(ADJ_REG_CMD);
    endtask

    task automatic level(input logic v);
        tick(1);
        mosi_o = v;
    endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench for the nfc frame codec core
// assumes the host model drives the spi pins; rf bits come from this module
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("BAD %0t got %0h exp %0h", $time, g, e); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock_i = 1'b0;
    logic rst_b_i, tx_start, irq_clr, osc_ok, i2c_en, bss_b, sclk, mosi;
    logic rx_clk, rx_data, rx_frame, pt_we;
    logic [15:0] wut;
    logic [5:0] pt_addr;
    logic [7:0] pt_wdata, pt_rdata;
    logic miso, miso_oe_b, tx_mod, irq, mcu_clk, meas_trig, tx_busy;
    nfc_pkg::nfc_ctrl_t ctrl;
    logic q[$];
    logic got[$];
    int failures = 0;
    int n_checks = 0;

    always #10 clock_i = ~clock_i;

    nfc_frame_codec_fifo dut_u (
        .clock_i(clock_i), .rst_b_i(rst_b_i), .ctrl_i(ctrl), .tx_start_i(tx_start),
        .irq_clr_i(irq_clr), .wut_period_i(wut), .osc_ok_i(osc_ok), .i2c_en_i(i2c_en),
        .bss_b_i(bss_b), .sclk_i(sclk), .mosi_i(mosi), .rx_clk_i(rx_clk),
        .rx_data_i(rx_data), .rx_frame_i(rx_frame), .pt_we_i(pt_we), .pt_addr_i(pt_addr),
        .pt_wdata_i(pt_wdata), .miso_o(miso), .miso_oe_b_o(miso_oe_b), .tx_mod_o(tx_mod),
        .irq_o(irq), .mcu_clk_o(mcu_clk), .meas_trig_o(meas_trig), .tx_busy_o(tx_busy),
        .pt_rdata_o(pt_rdata)
    );

    nfc_host_model host_u (
        .clock_i(clock_i), .bss_b_o(bss_b), .sclk_o(sclk), .mosi_o(mosi)
    );

    task automatic cyc(input int n);
        repeat (n) @(posedge clock_i);
        #2;
    endtask

    task automatic end_of_test();
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic add_byte(input logic [7:0] b, input logic bad);
        for (int i = 0; i < 8; i++) q.push_back(b[i]);
        q.push_back(~^b ^ bad);
    endtask

    // data byte then crc low and high, each with odd parity; bad makes the data byte's parity even
    task automatic build(input logic [7:0] b, input logic bad);
        logic [15:0] c;
        c = nfc_pkg::CRC_INIT;
        for (int i = 0; i < 8; i++)
            c = (c[0] ^ b[i]) ? ((c >> 1) ^ nfc_pkg::CRC_POLY) : (c >> 1);
        q.delete();
        add_byte(b, bad);
        add_byte(c[7:0], 1'b0);
        add_byte(c[15:8], 1'b0);
    endtask

    task automatic sbits(input logic [7:0] b);
        q.delete();
        for (int i = 0; i < 8; i++) q.push_back(b[i]);
    endtask

    task automatic set_mode(input nfc_pkg::nfc_mode_t m, input int len);
        ctrl.mode = m;
        ctrl.tx_len = 13'(len);
        cyc(2);
    endtask

    // mid-bit sampling tolerates a cycle or two of start lag
    task automatic tx_run(input int n);
        int k;
        got.delete();
        tx_start = 1'b1;
        cyc(1);
        tx_start = 1'b0;
        k = 0;
        while (tx_busy !== 1'b1 && k < 20) begin cyc(1); k++; end
        `CHK(tx_busy, 1'b1)
        cyc(3);
        repeat (n) begin got.push_back(tx_mod); cyc(8); end
        k = 0;
        while (tx_busy !== 1'b0 && k < 300) begin cyc(1); k++; end
        `CHK(tx_busy, 1'b0)
    endtask

    task automatic cmp_bits();
        foreach (q[i]) `CHK(got[i], q[i])
    endtask

    task automatic rf_send();
        rx_frame = 1'b1;
        cyc(4);
        foreach (q[i])
        begin
            rx_data = q[i];
            cyc(4);
            rx_clk = 1'b1;
            cyc(4);
            rx_clk = 1'b0;
        end
        cyc(4);
        rx_frame = 1'b0;
        rx_data = ~rx_data;
        cyc(8);
    endtask

    task automatic toggles(input logic [1:0] cfg, output int n);
        logic p;
        ctrl.clk_cfg = cfg;
        cyc(4);
        n = 0;
        repeat (40) begin p = mcu_clk; cyc(1); n += int'(mcu_clk !== p); end
    endtask

    task automatic t_ram();
        pt_addr = 6'h2f;
        pt_wdata = 8'h5a;
        pt_we = 1'b1;
        cyc(1);
        pt_we = 1'b0;
        cyc(2);
        `CHK(pt_rdata, 8'h00)
        ctrl.enable = 1'b1;
        cyc(1);
        pt_we = 1'b1;
        cyc(1);
        pt_we = 1'b0;
        cyc(2);
        `CHK(pt_rdata, 8'h5a)
        pt_addr = 6'h30;
        cyc(2);
        `CHK(pt_rdata, 8'h00)
    endtask

    task automatic t_osc();
        int n;
        cyc(30);
        `CHK(irq, 1'b0)
        osc_ok = 1'b1;
        cyc(10);
        `CHK(irq, 1'b0)
        cyc(15);
        `CHK(irq, 1'b1)
        toggles(2'h2, n);
        `CHK(n >= 19 && n <= 21, 1'b1)
        toggles(2'h0, n);
        `CHK(n, 0)
        irq_clr = 1'b1;
        cyc(1);
        irq_clr = 1'b0;
        cyc(1);
        `CHK(irq, 1'b0)
    endtask

    // a load with i2c selected must not reach the fifo
    task automatic t_stream_tx();
        set_mode(nfc_pkg::NFC_STREAM, 1);
        i2c_en = 1'b1;
        host_u.frame(nfc_pkg::CMD_FIFO_LOAD, '{8'hff});
        i2c_en = 1'b0;
        cyc(4);
        host_u.frame(nfc_pkg::CMD_FIFO_LOAD, '{8'ha5});
        sbits(8'ha5);
        tx_run(8);
        cmp_bits();
    endtask

    task automatic t_normal_tx();
        set_mode(nfc_pkg::NFC_NORMAL, 1);
        host_u.frame(nfc_pkg::CMD_FIFO_LOAD, '{8'h5a});
        build(8'h5a, 1'b0);
        q.push_front(nfc_pkg::SOF_LVL);
        q.push_back(nfc_pkg::EOF_LVL);
        tx_run(29);
        cmp_bits();
    endtask

    task automatic t_stream_rx();
        set_mode(nfc_pkg::NFC_STREAM, 1);
        sbits(8'hc3);
        rf_send();
        tx_run(8);
        cmp_bits();
    endtask

    // good frame keeps data and crc bytes; parity slips raise the interrupt
    task automatic t_normal_rx();
        logic s[$];
        set_mode(nfc_pkg::NFC_NORMAL, 1);
        build(8'h5a, 1'b0);
        rf_send();
        `CHK(irq, 1'b0)
        foreach (q[i]) if (i % 9 != 8) s.push_back(q[i]);
        q = s;
        set_mode(nfc_pkg::NFC_STREAM, 3);
        tx_run(24);
        cmp_bits();
        set_mode(nfc_pkg::NFC_NORMAL, 1);
        build(8'h5a, 1'b1);
        rf_send();
        `CHK(irq, 1'b1)
    endtask

    task automatic t_transparent();
        set_mode(nfc_pkg::NFC_TRANSPARENT, 1);
        for (int v = 0; v < 2; v++)
        begin
            host_u.level(v[0]);
            rx_data = ~v[0];
            cyc(6);
            `CHK(tx_mod, v[0])
            `CHK(miso, ~v[0])
            `CHK(miso_oe_b, 1'b0)
        end
    endtask

    task automatic t_wake();
        int n;
        ctrl = '0;
        ctrl.wake = 1'b1;
        wut = 16'h0005;
        n = 0;
        while (meas_trig !== 1'b1 && n < 50) begin cyc(1); n++; end
        cyc(1);
        n = 1;
        while (meas_trig !== 1'b1 && n < 50) begin cyc(1); n++; end
        `CHK(n, 6)
    endtask

    // whole run needs well under 20k cycles
    initial
    begin
        #500000;
        failures++;
        end_of_test();
    end

    initial
    begin
        ctrl = '0;
        {rst_b_i, tx_start, irq_clr, osc_ok, i2c_en} = '0;
        {rx_clk, rx_data, rx_frame, pt_we, pt_addr, pt_wdata} = '0;
        wut = 16'h0000;
        cyc(12);
        rst_b_i = 1'b1;
        cyc(3);
        `CHK({miso, tx_mod, irq, mcu_clk, meas_trig, tx_busy, pt_rdata}, 14'h0)
        `CHK(miso_oe_b, 1'b1)
        host_u.init();
        t_ram();
        t_osc();
        t_stream_tx();
        t_normal_tx();
        t_stream_rx();
        t_normal_rx();
        t_transparent();
        t_wake();
        end_of_test();
    end
endmodule
